// [design/hrif_defs.vh]
// Constants for the host register interface: strap codes, serial frame
// layout, local register addresses and pin-configuration fields.
// Assumes inclusion by bare name from design files under design/.
`ifndef HRIF_DEFS_VH
`define HRIF_DEFS_VH

// ----------------------------------------------------------------------
// Interface-select strap codes
// ----------------------------------------------------------------------
`define HRIF_MODE_SS_MUX 3'h2
`define HRIF_MODE_SS_NMUX 3'h3
`define HRIF_MODE_STB_NMUX 3'h4
`define HRIF_MODE_SPI_LSB 3'h5
`define HRIF_MODE_STB_MUX 3'h6
`define HRIF_MODE_SPI_MSB 3'h7
`define HRIF_MODE_RESET 3'h0

// ----------------------------------------------------------------------
// Serial frame: one direction bit, nine address bits, eight data bits
// ----------------------------------------------------------------------
`define HRIF_SPI_ADDR_END 5'h0A
`define HRIF_SPI_FRAME_END 5'h12

// ----------------------------------------------------------------------
// Locally held registers
// ----------------------------------------------------------------------
`define HRIF_IRQCFG_ADDR 9'h1F0
`define HRIF_MODE_ADDR 9'h1F1
`define HRIF_IRQCFG_RESET 8'h00

// Field positions inside irq_pin_config
`define HRIF_IRQCFG_POL 0
`define HRIF_IRQCFG_OD 1
`define HRIF_IRQCFG_GPO 2
`define HRIF_IRQCFG_GPV 3

// Parallel read: cycles the bus is driven before ready goes low
`define HRIF_RD_LAT 2'h2

`endif

// [design/hrif_regmem.v]
// Register storage for the host port: one write port, one read port.
// Assumes a single clock; read data leaves through a register.
`timescale 1ns/10ps

module hrif_regmem #(
  parameter AW = 9,
  parameter DW = 8
) (
  // Clock, reset, enable
  input wire core_clk_in,
  input wire resetn_in,
  input wire ce_in,
  // Write port
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [DW-1:0] wr_data_in,
  // Read port
  input wire [AW-1:0] rd_addr_in,
  output reg [DW-1:0] rd_data_out
);

  // Storage array; contents are undefined until software writes them
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  // ----------------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------------
  // No reset on the array so it maps onto plain RAM
  always @(posedge core_clk_in) begin
    if (ce_in && wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // ----------------------------------------------------------------------
  // Registered read
  // ----------------------------------------------------------------------
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= {DW{1'b0}};
    end else if (ce_in) begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end

endmodule

// [design/hrif_host_port.v]
// Host register port: parallel (separate or data strobe, muxed or not)
// and serial access to a 512-byte register space, and the irq pin.
// Assumes host pins are asynchronous to core_clk_in and the serial
// clock is far slower than the core clock.
`timescale 1ns/10ps
`include "hrif_defs.vh"

module hrif_host_port #(
  parameter AW = 9,
  parameter DW = 8
) (
  // Clock, reset, enable
  input wire core_clk_in,
  input wire resetn_in,
  input wire ce_in,
  // Mode straps
  input wire [2:0] host_if_select_in,
  // Parallel control pins
  input wire cs_n_in,
  input wire ale_in,
  input wire wr_n_rw_in,
  input wire rd_n_data_strobe_n_in,
  input wire [AW-1:0] addr_in,
  // Shared address/data pins
  input wire [DW-1:0] ad_in,
  output reg [DW-1:0] ad_out,
  output reg ad_oe_out,
  output reg rdy_n_out,
  // Serial pins
  input wire sclk_in,
  input wire sdi_in,
  input wire cpha_in,
  input wire cpol_in,
  output reg sdo_out,
  output reg sdo_oe_out,
  // Interrupt source and pin
  input wire core_irq_in,
  output reg irq_out,
  output reg irq_oe_out,
  // Captured mode for the rest of the device
  output reg [2:0] mode_out
);

  // ----------------------------------------------------------------------
  // Mode decode helpers
  // ----------------------------------------------------------------------
  function is_spi;
    input [2:0] m;
    begin
      is_spi = (m == `HRIF_MODE_SPI_LSB) || (m == `HRIF_MODE_SPI_MSB);
    end
  endfunction

  // Mode classes of the captured straps
  wire mode_mux = (mode_out == `HRIF_MODE_SS_MUX) ||
                  (mode_out == `HRIF_MODE_STB_MUX);
  wire mode_stb = (mode_out == `HRIF_MODE_STB_NMUX) ||
                  (mode_out == `HRIF_MODE_STB_MUX);
  wire mode_par = (mode_out[2:1] != 2'h0) && !is_spi(mode_out);

  // ----------------------------------------------------------------------
  // Pin synchronisers: three stages, accept when stages two and three agree
  // ----------------------------------------------------------------------
  localparam NP = 8 + AW + DW;
  wire [NP-1:0] pin_raw;
  wire [NP-1:0] pin_f;  // Filtered pin levels
  reg [NP-1:0] pin_fp_q;  // Filtered levels one cycle back

  assign pin_raw = {cs_n_in, ale_in, wr_n_rw_in, rd_n_data_strobe_n_in,
                    sclk_in, sdi_in, cpha_in, cpol_in, addr_in, ad_in};

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg f_q;
      // Reset to one: idle level of chip select and the strobes
      always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          f_q <= 1'b1;
        end else if (ce_in) begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            f_q <= s3_q;
          end
        end
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  // Named views of the filtered pins
  wire cs_n_f = pin_f[NP-1];
  wire ale_f = pin_f[NP-2];
  wire wr_f = pin_f[NP-3];
  wire rd_f = pin_f[NP-4];
  wire sclk_f = pin_f[NP-5];
  wire sdi_f = pin_f[NP-6];
  wire cpha_f = pin_f[NP-7];
  wire cpol_f = pin_f[NP-8];
  wire [AW-1:0] a_f = pin_f[AW+DW-1:DW];
  wire [DW-1:0] ad_f = pin_f[DW-1:0];
  wire sclk_p = pin_fp_q[NP-5];

  // ----------------------------------------------------------------------
  // Strap capture: first enabled cycle after reset release
  // ----------------------------------------------------------------------
  reg strap_done_q;
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_done_q <= 1'b0;
      mode_out <= `HRIF_MODE_RESET;
      pin_fp_q <= {NP{1'b1}};
    end else if (ce_in) begin
      pin_fp_q <= pin_f;
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        mode_out <= host_if_select_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Parallel cycle decode
  // ----------------------------------------------------------------------
  reg [AW-1:0] addr_q;  // Address latch
  reg [DW-1:0] wdat_q;  // Data held while the write strobe is low
  reg par_wr_prev_q;
  reg [1:0] rd_cnt_q;
  reg par_rd;
  reg par_wr;
  wire par_en = strap_done_q && mode_par;

  // Bus activity only counts with chip select low
  always @* begin
    par_rd = 1'b0;
    par_wr = 1'b0;
    if (par_en && !cs_n_f) begin
      if (mode_stb) begin
        par_rd = !rd_f && wr_f;
        par_wr = !rd_f && !wr_f;
      end else begin
        par_rd = !rd_f;
        par_wr = !wr_f;
      end
    end
  end

  // Commit on the trailing edge of the write strobe, data from last cycle
  wire par_commit = par_wr_prev_q && !par_wr;

  // ----------------------------------------------------------------------
  // Parallel datapath
  // ----------------------------------------------------------------------
  wire [DW-1:0] mem_rdata;
  reg [DW-1:0] rd_word;

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q <= {AW{1'b0}};
      wdat_q <= {DW{1'b0}};
      par_wr_prev_q <= 1'b0;
      rd_cnt_q <= 2'h0;
      ad_out <= {DW{1'b0}};
      ad_oe_out <= 1'b0;
      rdy_n_out <= 1'b1;
    end else if (ce_in) begin
      par_wr_prev_q <= par_wr;
      // Latch is transparent while enable is high
      if (par_en && ale_f) begin
        if (mode_mux) begin
          addr_q <= {a_f[AW-1], ad_f};
        end else begin
          addr_q <= a_f;
        end
      end
      if (par_wr) begin
        wdat_q <= ad_f;
      end
      // Drive the bus only during reads
      ad_oe_out <= par_rd;
      ad_out <= par_rd ? rd_word : {DW{1'b0}};
      if (!par_rd) begin
        rd_cnt_q <= 2'h0;
      end else if (rd_cnt_q != `HRIF_RD_LAT) begin
        rd_cnt_q <= rd_cnt_q + 2'h1;
      end
      // Ready once read data is on the pins or the write is held
      rdy_n_out <= !((par_rd && rd_cnt_q == `HRIF_RD_LAT) || par_wr);
    end
  end

  // ----------------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------------
  reg [4:0] bit_cnt_q;  // Bits sampled in this frame
  reg spi_rw_q;  // One means read
  reg [AW-1:0] spi_addr_q;
  reg [DW-1:0] spi_data_q;
  wire spi_en = strap_done_q && is_spi(mode_out);
  wire spi_sel = spi_en && !cs_n_f;
  wire lsb_first = (mode_out == `HRIF_MODE_SPI_LSB);
  // Leading edge leaves the idle level set by polarity
  wire sclk_edge = (sclk_f != sclk_p);
  wire lead_edge = sclk_edge && (sclk_p == cpol_f);
  // Sample edge picked by phase, the other edge shifts out
  wire samp_edge = cpha_f ? (sclk_edge && !lead_edge) : lead_edge;
  wire shift_edge = sclk_edge && !samp_edge;
  wire [4:0] data_idx = bit_cnt_q - `HRIF_SPI_ADDR_END;
  wire [2:0] out_idx = lsb_first ? data_idx[2:0] : 3'h7 - data_idx[2:0];
  // Last sample seen; the write waits a cycle for the final data bit
  wire spi_last = spi_sel && samp_edge && !spi_rw_q &&
                  bit_cnt_q == `HRIF_SPI_FRAME_END - 5'h1;
  reg spi_commit_q;  // Serial write strobe, one cycle

  // Serial clock comes only from the host; it is sampled here
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_cnt_q <= 5'h00;
      spi_rw_q <= 1'b0;
      spi_addr_q <= {AW{1'b0}};
      spi_data_q <= {DW{1'b0}};
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
      spi_commit_q <= 1'b0;
    end else if (ce_in) begin
      sdo_oe_out <= spi_sel;
      spi_commit_q <= spi_last;
      if (!spi_sel) begin
        // Frame ends with chip select
        bit_cnt_q <= 5'h00;
        sdo_out <= 1'b0;
      end else begin
        if (samp_edge && bit_cnt_q != `HRIF_SPI_FRAME_END) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          // Direction, then address, then data
          if (bit_cnt_q == 5'h00) begin
            spi_rw_q <= sdi_f;
          end else if (bit_cnt_q < `HRIF_SPI_ADDR_END) begin
            if (lsb_first) begin
              spi_addr_q <= {sdi_f, spi_addr_q[AW-1:1]};
            end else begin
              spi_addr_q <= {spi_addr_q[AW-2:0], sdi_f};
            end
          end else if (lsb_first) begin
            spi_data_q <= {sdi_f, spi_data_q[DW-1:1]};
          end else begin
            spi_data_q <= {spi_data_q[DW-2:0], sdi_f};
          end
        end
        // Read data goes out one bit per shift edge
        if (shift_edge && spi_rw_q && bit_cnt_q >= `HRIF_SPI_ADDR_END &&
            bit_cnt_q != `HRIF_SPI_FRAME_END) begin
          sdo_out <= rd_word[out_idx];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register storage and locally held registers
  // ----------------------------------------------------------------------
  reg [DW-1:0] irq_cfg_q;  // irq_pin_config
  wire mem_we = par_commit || spi_commit_q;
  wire [AW-1:0] mem_addr = spi_en ? spi_addr_q : addr_q;
  wire [DW-1:0] mem_wdata = spi_en ? spi_data_q : wdat_q;

  // Mode register reads back the captured straps
  always @* begin
    if (mem_addr == `HRIF_MODE_ADDR) begin
      rd_word = {{(DW-3){1'b0}}, mode_out};
    end else if (mem_addr == `HRIF_IRQCFG_ADDR) begin
      rd_word = irq_cfg_q;
    end else begin
      rd_word = mem_rdata;
    end
  end

  hrif_regmem #(.AW(AW), .DW(DW)) u_mem (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_addr),
    .wr_data_in(mem_wdata),
    .rd_addr_in(mem_addr),
    .rd_data_out(mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------------
  wire irq_act = irq_cfg_q[`HRIF_IRQCFG_GPO] ?
                 irq_cfg_q[`HRIF_IRQCFG_GPV] : core_irq_in;
  wire irq_lvl = irq_cfg_q[`HRIF_IRQCFG_POL] ? irq_act : !irq_act;

  // Open drain only ever pulls low; the pin floats otherwise
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_cfg_q <= `HRIF_IRQCFG_RESET;
      irq_out <= 1'b1;
      irq_oe_out <= 1'b0;
    end else if (ce_in) begin
      if (mem_we && mem_addr == `HRIF_IRQCFG_ADDR) begin
        irq_cfg_q <= mem_wdata;
      end
      irq_out <= irq_cfg_q[`HRIF_IRQCFG_OD] ? 1'b0 : irq_lvl;
      irq_oe_out <= irq_cfg_q[`HRIF_IRQCFG_OD] ? !irq_lvl : 1'b1;
    end
  end

endmodule

// [tb/hrif_spi_host.sv]
// Serial host model: frames direction, address and data on the pins.
// Assumes cpol, cpha and bit order are steady while a frame runs.
`timescale 1ns/10ps
module hrif_spi_host (
  // Frame format controls
  input wire cpol_in,
  input wire cpha_in,
  input wire lsb_in,
  // Serial pins
  input wire sdo_in,
  output reg cs_n_out,
  output reg sclk_out,
  output reg sdi_out
);
  // Idle: not selected, clock still
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // One 18-bit frame; clock runs only inside it
  task xfer(input rd, input [8:0] a, input [7:0] wd, output [7:0] q);
    reg [17:0] f;
    integer i;
    begin
      f[17] = rd;
      for (i = 0; i < 9; i = i + 1) f[16-i] = lsb_in ? a[i] : a[8-i];
      for (i = 0; i < 8; i = i + 1) f[7-i] = lsb_in ? wd[i] : wd[7-i];
      q = 8'h00;
      sclk_out = cpol_in; // Rest level
      #100; // Clock settles and chip select rests high between frames
      cs_n_out = 1'b0;
      #100;
      for (i = 0; i < 18; i = i + 1) begin
        if (!cpha_in) sdi_out = f[17-i]; // Set up before lead
        #62.5;
        if (!cpha_in && i > 9) q[lsb_in ? i-10 : 17-i] = sdo_in;
        sclk_out = ~cpol_in;
        if (cpha_in) sdi_out = f[17-i]; // Set up before trail
        #62.5;
        if (cpha_in && i > 9) q[lsb_in ? i-10 : 17-i] = sdo_in;
        sclk_out = cpol_in;
      end
      #100;
      cs_n_out = 1'b1;
      sdi_out = ~sdi_out; // Released line must not look held
    end
  endtask
endmodule

// [tb/hrif_host_port_properties.sv]
// Checker for the host port: bus drive, ready and mode relations.
// Assumes binding to hrif_host_port; sees only its ports.
`timescale 1ns/10ps
module hrif_props (
  input wire core_clk_in,
  input wire resetn_in,
  input wire cs_n_in,
  input wire wr_n_rw_in,
  input wire rd_n_data_strobe_n_in,
  input wire [7:0] ad_out,
  input wire ad_oe_out,
  input wire rdy_n_out,
  input wire sdo_oe_out,
  input wire [2:0] mode_out
);
  // ----
  // Single clock domain
  // ----
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  a_read_strobe: assert property ($rose(ad_oe_out) |-> !cs_n_in &&
    !rd_n_data_strobe_n_in) else $error("bus driven without strobe");
  a_read_dir: assert property ($rose(ad_oe_out) |-> wr_n_rw_in)
    else $error("bus driven in a write");
  a_read_ready: assert property ($rose(ad_oe_out) |-> ##2 !rdy_n_out)
    else $error("read ready late");
  a_ready_holds: assert property ($fell(rdy_n_out) |-> !rdy_n_out [*3])
    else $error("ready too short");
  a_ready_cs: assert property (!rdy_n_out |-> !cs_n_in)
    else $error("ready without chip select");
  a_bus_idle: assert property (!ad_oe_out |-> ad_out == 8'h00)
    else $error("bus data outside read");
  a_drive_mode: assert property (ad_oe_out |->
    mode_out inside {3'h2, 3'h3, 3'h4, 3'h6}) else $error("drive in bad mode");
  a_serial_mode: assert property (sdo_oe_out |->
    mode_out inside {3'h5, 3'h7}) else $error("serial out in bad mode");
  a_mode_held: assert property (mode_out != 3'h0 |=> $stable(mode_out))
    else $error("mode changed");
endmodule
bind hrif_host_port hrif_props i_props (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .cs_n_in(cs_n_in),
  .wr_n_rw_in(wr_n_rw_in), .rd_n_data_strobe_n_in(rd_n_data_strobe_n_in),
  .ad_out(ad_out), .ad_oe_out(ad_oe_out), .rdy_n_out(rdy_n_out),
  .sdo_oe_out(sdo_oe_out), .mode_out(mode_out));

// [tb/testbench.sv]
// Testbench for the host port: parallel and serial register access.
// Assumes the design under design/ and the serial host model.
`timescale 1ns/10ps
module testbench;
  // ----
  // Stimulus and observed signals
  // ----
  reg clk = 1'b0, resetn = 1'b0, cs_p = 1'b1, ale = 1'b1, wr = 1'b1;
  reg dstb = 1'b1, irq = 1'b0, cpol = 1'b0, cpha = 1'b0;
  reg [2:0] sel = 3'h3;
  reg [8:0] addr = 9'h000;
  reg [7:0] hv = 8'h00, q;
  wire cs_s, sclk, sdi, sdo, sdo_oe, ad_oe, rdy_n, irq_o, irq_oe;
  wire [7:0] ad_o;
  wire [2:0] mode;
  integer fail_count = 0, samples_checked = 0, m, k;
  wire muxed = (sel == 3'h2) || (sel == 3'h6);
  wire [7:0] ad_bus = ad_oe ? ad_o : hv; // Wire level of shared bus
  always #2 clk = ~clk;
  hrif_host_port i_dut (.core_clk_in(clk), .resetn_in(resetn), .ce_in(1'b1),
    .host_if_select_in(sel), .cs_n_in(cs_p & cs_s), .ale_in(ale),
    .wr_n_rw_in(wr), .rd_n_data_strobe_n_in(dstb), .addr_in(addr),
    .ad_in(ad_bus), .ad_out(ad_o), .ad_oe_out(ad_oe), .rdy_n_out(rdy_n),
    .sclk_in(sclk), .sdi_in(sdi), .cpha_in(cpha), .cpol_in(cpol),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .core_irq_in(irq),
    .irq_out(irq_o), .irq_oe_out(irq_oe), .mode_out(mode));
  hrif_spi_host i_host (.cpol_in(cpol), .cpha_in(cpha),
    .lsb_in(sel == 3'h5), .sdo_in(sdo), .cs_n_out(cs_s), .sclk_out(sclk),
    .sdi_out(sdi));
  // Compare one value, count it
  task chk(input [8*8:1] nm, input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Bounded wait for ready level; a hang ends the run
  task wrdy(input v);
    integer n;
    begin
      n = 0;
      while (rdy_n !== v && n < 40) begin
        @(negedge clk);
        n = n + 1;
      end
      if (rdy_n !== v) begin
        fail_count = fail_count + 1;
        $display("Error rdy_n expected %b seen %b", v, rdy_n);
        summarize;
      end
    end
  endtask
  // Reset with a strap code
  task rst(input [2:0] c);
    begin
      resetn = 1'b0;
      sel = c;
      ale = ~((c == 3'h2) || (c == 3'h6)); // Transparent unless muxed
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      if (c > 3'h1) chk("mode", {5'h00, mode}, {5'h00, c});
    end
  endtask
  // One parallel access; read data lands in q
  task pacc(input rd, input [8:0] a, input [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      hv = a[7:0];
      if (muxed) begin
        ale = 1'b1; // Pulse latches A8 and AD
        repeat (6) @(negedge clk);
        ale = 1'b0;
        addr[7:0] = ~a[7:0]; // Low pins must be ignored
      end
      hv = rd ? ~hv : d;
      cs_p = 1'b0;
      if (sel[2]) wr = rd; // Direction 1 reads
      @(negedge clk);
      if (sel[2] || rd) dstb = 1'b0;
      else wr = 1'b0;
      wrdy(1'b0);
      q = ad_bus;
      if (rd) chk("ad_oe", {7'h00, ad_oe}, 8'h01);
      dstb = 1'b1; // Strobe rise latches writes
      if (!sel[2]) wr = 1'b1;
      wrdy(1'b1);
      wr = 1'b1;
      cs_p = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask
  // Strobe that must be ignored
  task quiet(input c);
    begin
      @(negedge clk);
      cs_p = c;
      dstb = 1'b0;
      repeat (12) @(negedge clk);
      chk("rdy_n", {7'h00, rdy_n}, 8'h01);
      chk("ad_oe", {7'h00, ad_oe}, 8'h00);
      dstb = 1'b1;
      cs_p = 1'b1;
      repeat (6) @(negedge clk);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    rst(3'h3);
    quiet(1'b1);
    for (m = 2; m < 7; m = m + 1) if (m != 5) begin
      rst(m[2:0]);
      pacc(1'b0, {m[0], 8'hA0 + m[7:0]}, 8'h3C ^ m[7:0]);
      pacc(1'b1, {m[0], 8'hA0 + m[7:0]}, 8'h00);
      chk("rdata", q, 8'h3C ^ m[7:0]);
      pacc(1'b1, 9'h1F1, 8'h00);
      chk("modereg", q, {5'h00, m[2:0]});
      $display("test parallel mode %0d done", m);
    end
    pacc(1'b1, 9'h1F0, 8'h00);
    chk("irqcfg", q, 8'h00);
    // Config, source, expected pin value and enable per row
    for (k = 0; k < 8; k = k + 1) begin
      pacc(1'b0, 9'h1F0, 64'h040C020201010000 >> (k * 8));
      irq = 8'h96 >> k;
      repeat (6) @(negedge clk);
      chk("irq_oe", {7'h00, irq_oe}, {7'h00, 8'hDF >> k & 8'h01});
      if (k != 5) chk("irq", {7'h00, irq_o}, 8'h85 >> k & 8'h01);
    end
    $display("test interrupt pin done");
    rst(3'h1);
    quiet(1'b0);
    for (m = 5; m < 8; m = m + 2) begin
      rst(m[2:0]);
      for (k = 0; k < 4; k = k + 1) begin
        @(negedge clk);
        cpol = k[1];
        cpha = k[0];
        i_host.xfer(1'b0, {k[0], 8'h3A + k[7:0]}, 8'hC5 ^ k[7:0], q);
        i_host.xfer(1'b1, {k[0], 8'h3A + k[7:0]}, 8'h00, q);
        chk("sdata", q, 8'hC5 ^ k[7:0]);
      end
      i_host.xfer(1'b1, 9'h1F1, 8'h00, q);
      chk("sorder", q, {5'h00, m[2:0]});
      $display("test serial mode %0d done", m);
    end
    summarize;
  end
endmodule
